// ---- hdl/hps_debounce.sv ----
// Contact debounce filter for one general input.
// Assumes the input is already synchronised and tick is a one-cycle pulse.
`timescale 1ns/1ns
`default_nettype none

module hps_debounce #(
    parameter int unsigned WINDOW_TICKS = hps_pkg::DEBOUNCE_TICKS
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Sampling
    input wire logic tick,
    input wire logic level_in,
    // Filtered level
    output logic level_out
);
    import hps_pkg::*;

    localparam logic [DEBOUNCE_W-1:0] LAST =
        DEBOUNCE_W'(WINDOW_TICKS - 1);

    logic [DEBOUNCE_W-1:0] count_q;

    // A bounce back to the old level restarts the window.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            count_q <= '0;
        else if (level_in == level_out)
            count_q <= '0;
        else if (tick && count_q != LAST)
            count_q <= count_q + 1'b1;
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            level_out <= 1'b0;
        else if (tick && level_in != level_out && count_q == LAST)
            level_out <= level_in;
    end

endmodule
`default_nettype wire

// ---- hdl/hps_fault_timer.sv ----
// Fault timer for one slot: counts ticks while a fault event persists.
// Assumes tick is a one-cycle pulse and limit is held steady by the host.
`timescale 1ns/1ns
`default_nettype none

module hps_fault_timer #(
    parameter int unsigned WIDTH = hps_pkg::TIMER_W
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Timing
    input wire logic tick,
    input wire logic [WIDTH-1:0] limit,
    // Event and result
    input wire logic event_active,
    output logic expired
);
    import hps_pkg::*;

    logic [WIDTH-1:0] count_q;

    // The count drops at once when the event ends, like a fast discharge.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            count_q <= '0;
        else if (!event_active)
            count_q <= '0;
        else if (tick && count_q < limit)
            count_q <= count_q + 1'b1;
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            expired <= 1'b0;
        else
            expired <= event_active && (count_q >= limit);
    end

endmodule
`default_nettype wire

// ---- hdl/hps_pkg.sv ----
// Shared constants and carriers for the dual-slot hot plug fault control.
// Assumes a single 50 MHz clock and one asynchronous active-high reset.
package hps_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CLOCK_PERIOD_NS = 20;
    localparam int unsigned TICK_PERIOD_NS = 1000;
    localparam int unsigned TICK_CYCLES =
        (TICK_PERIOD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int unsigned TICK_W = 8;
    localparam int unsigned DEBOUNCE_MS = 5;
    localparam int unsigned NS_PER_MS = 1000000;
    localparam int unsigned DEBOUNCE_TICKS =
        DEBOUNCE_MS * NS_PER_MS / TICK_PERIOD_NS;
    localparam int unsigned DEBOUNCE_W = 16;
    localparam int unsigned TIMER_W = 16;

    // The removal threshold is applied by the analog low comparator.
    localparam int unsigned LOW_THRESHOLD_MV = 100;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int unsigned NUM_SLOTS = 2;
    localparam int unsigned GPI_PER_SLOT = 2;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic main_power_enable;
        logic aux_power_enable;
        logic slot_override_on_n;
        logic slot_general_input_1;
        logic slot_general_input_2;
        logic sense_low_12v_trip;
        logic sense_low_3v3_trip;
        logic aux_over_current;
        logic main_under_voltage;
        logic aux_under_voltage;
        logic main_in_range;
        logic aux_in_range;
        logic all_below_low;
    } hps_pins_s;

    localparam hps_pins_s PINS_RESET = '{slot_override_on_n: 1'b1,
                                         default: 1'b0};

    typedef struct packed {
        logic main_on;
        logic aux_on;
        logic main_fault;
        logic aux_fault;
        logic override_active;
        logic power_good;
        logic power_off;
        logic thermal_off;
    } hps_state_s;

    localparam hps_state_s STATE_RESET = '{default: 1'b0};

endpackage

// ---- hdl/hps_slot_ctl.sv ----
// Dual-slot hot plug enable, fault, override and status logic.
// Assumes analog comparators deliver asynchronous levels on the pins.
`timescale 1ns/1ns
`default_nettype none

module hps_slot_ctl #(
    parameter int unsigned DEBOUNCE_TICKS = hps_pkg::DEBOUNCE_TICKS,
    parameter int unsigned TIMER_WIDTH = hps_pkg::TIMER_W
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Slot pins and comparators
    input wire hps_pkg::hps_pins_s [hps_pkg::NUM_SLOTS-1:0] slot_pins,
    input wire logic thermal_shutdown,
    // Host control
    input wire logic [hps_pkg::NUM_SLOTS-1:0] override_inhibit,
    input wire logic [hps_pkg::NUM_SLOTS-1:0][TIMER_WIDTH-1:0]
        fault_timer_cap,
    // Power switch enables
    output logic [hps_pkg::NUM_SLOTS-1:0] main_power_on,
    output logic [hps_pkg::NUM_SLOTS-1:0] aux_slot_output,
    // Open-drain indicator pins
    output logic [hps_pkg::NUM_SLOTS-1:0] slot_fault_n,
    output logic [hps_pkg::NUM_SLOTS-1:0] slot_fault_n_oe_n,
    output logic [hps_pkg::NUM_SLOTS-1:0] slot_power_good_n,
    output logic [hps_pkg::NUM_SLOTS-1:0] slot_power_good_n_oe_n,
    // Host status
    output hps_pkg::hps_state_s [hps_pkg::NUM_SLOTS-1:0] slot_state_reg,
    output logic [hps_pkg::NUM_SLOTS*hps_pkg::GPI_PER_SLOT-1:0]
        common_status
);
    import hps_pkg::*;

    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    hps_pins_s [NUM_SLOTS-1:0] pins_meta_q;
    hps_pins_s [NUM_SLOTS-1:0] pins_q;
    logic thermal_meta_q;
    logic thermal_q;

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            pins_meta_q <= {NUM_SLOTS{PINS_RESET}};
            pins_q <= {NUM_SLOTS{PINS_RESET}};
        end
        else
        begin
            pins_meta_q <= slot_pins;
            pins_q <= pins_meta_q;
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            thermal_meta_q <= 1'b0;
            thermal_q <= 1'b0;
        end
        else
        begin
            thermal_meta_q <= thermal_shutdown;
            thermal_q <= thermal_meta_q;
        end
    end

    // ------------------------------------------------------------------
    // Microsecond tick
    // ------------------------------------------------------------------
    // One slow enable serves both the debounce and the fault timers, so
    // neither needs a wide cycle counter of its own.
    logic [TICK_W-1:0] tick_count_q;
    logic tick_q;

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            tick_count_q <= '0;
        else if (tick_count_q == TICK_LAST)
            tick_count_q <= '0;
        else
            tick_count_q <= tick_count_q + 1'b1;
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            tick_q <= 1'b0;
        else
            tick_q <= (tick_count_q == TICK_LAST);
    end

    // ------------------------------------------------------------------
    // Per-slot logic
    // ------------------------------------------------------------------
    // Independent slot copies.
    for (genvar s = 0; s < NUM_SLOTS; s++)
    begin : g_slot
        logic main_event;
        logic aux_event;
        logic timer_expired;
        logic override_active;
        logic main_fault_q;
        logic aux_fault_q;
        logic main_on_q;
        logic aux_on_q;
        logic fault_drive_q;
        logic good_drive_q;
        logic power_off_q;
        logic gpi_1;
        logic gpi_2;

        // Sense trips as over-current.
        // Events count only while the supply is enabled, since a supply
        // that is off is always under voltage.
        assign main_event = pins_q[s].main_power_enable &&
            (pins_q[s].sense_low_12v_trip || pins_q[s].sense_low_3v3_trip
             || pins_q[s].main_under_voltage || thermal_q);
        assign aux_event = pins_q[s].aux_power_enable &&
            (pins_q[s].aux_over_current || pins_q[s].aux_under_voltage
             || thermal_q);

        hps_fault_timer #(
            .WIDTH(TIMER_WIDTH)
        ) u_timer (
            .clock(clock),
            .rst(rst),
            .tick(tick_q),
            .limit(fault_timer_cap[s]),
            .event_active(main_event || aux_event),
            .expired(timer_expired)
        );

        assign override_active = !pins_q[s].slot_override_on_n &&
            !override_inhibit[s];

        // Latch main fault.
        // A new expiry wins over a clear in the same cycle.
        always_ff @(posedge clock or posedge rst)
        begin
            if (rst)
                main_fault_q <= 1'b0;
            else if (timer_expired && main_event)
                main_fault_q <= 1'b1;
            else if (!pins_q[s].main_power_enable)
                main_fault_q <= 1'b0;
        end

        always_ff @(posedge clock or posedge rst)
        begin
            if (rst)
                aux_fault_q <= 1'b0;
            else if (timer_expired && aux_event)
                aux_fault_q <= 1'b1;
            else if (!pins_q[s].aux_power_enable)
                aux_fault_q <= 1'b0;
        end

        always_ff @(posedge clock or posedge rst)
        begin
            if (rst)
                main_on_q <= 1'b0;
            else
                main_on_q <= pins_q[s].main_power_enable && !thermal_q &&
                    (!(main_fault_q || aux_fault_q) || override_active);
        end

        always_ff @(posedge clock or posedge rst)
        begin
            if (rst)
                aux_on_q <= 1'b0;
            else
                aux_on_q <= pins_q[s].aux_power_enable && !thermal_q &&
                    (!aux_fault_q || override_active);
        end

        always_ff @(posedge clock or posedge rst)
        begin
            if (rst)
                fault_drive_q <= 1'b0;
            else
                fault_drive_q <= main_fault_q || aux_fault_q;
        end

        always_ff @(posedge clock or posedge rst)
        begin
            if (rst)
                good_drive_q <= 1'b0;
            else
                good_drive_q <= main_on_q && aux_on_q &&
                    pins_q[s].main_in_range && pins_q[s].aux_in_range;
        end

        // Safe-removal status.
        // The status follows the comparator while main stays off.
        always_ff @(posedge clock or posedge rst)
        begin
            if (rst)
                power_off_q <= 1'b0;
            else
                power_off_q <= !main_on_q && pins_q[s].all_below_low;
        end

        hps_debounce #(
            .WINDOW_TICKS(DEBOUNCE_TICKS)
        ) u_gpi_1 (
            .clock(clock),
            .rst(rst),
            .tick(tick_q),
            .level_in(pins_q[s].slot_general_input_1),
            .level_out(gpi_1)
        );

        hps_debounce #(
            .WINDOW_TICKS(DEBOUNCE_TICKS)
        ) u_gpi_2 (
            .clock(clock),
            .rst(rst),
            .tick(tick_q),
            .level_in(pins_q[s].slot_general_input_2),
            .level_out(gpi_2)
        );

        assign common_status[s*GPI_PER_SLOT] = gpi_1;
        assign common_status[s*GPI_PER_SLOT+1] = gpi_2;

        assign main_power_on[s] = main_on_q;
        assign aux_slot_output[s] = aux_on_q;

        // Open-drain pins only ever pull low; the enable is active low.
        assign slot_fault_n[s] = 1'b0;
        assign slot_fault_n_oe_n[s] = !fault_drive_q;
        assign slot_power_good_n[s] = 1'b0;
        assign slot_power_good_n_oe_n[s] = !good_drive_q;

        assign slot_state_reg[s].main_on = main_on_q;
        assign slot_state_reg[s].aux_on = aux_on_q;
        assign slot_state_reg[s].main_fault = main_fault_q;
        assign slot_state_reg[s].aux_fault = aux_fault_q;
        assign slot_state_reg[s].override_active = override_active;
        assign slot_state_reg[s].power_good = good_drive_q;
        assign slot_state_reg[s].power_off = power_off_q;
        assign slot_state_reg[s].thermal_off = thermal_q;
    end

endmodule
`default_nettype wire

// ---- sim/hot_plug_slot_fault_control_test.sv ----
// Self-checking bench for the dual-slot hot plug fault control.
// Assumes the block, its bound checker and the rail model.
`timescale 1ns/1ns
`default_nettype none
module hot_plug_slot_fault_control_test;
    import hps_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic thermal_shutdown = 1'b0;
    logic [1:0] override_inhibit = 2'h0;
    logic [1:0][15:0] fault_timer_cap = {16'h0003, 16'h0003};
    hps_pins_s [1:0] drv = {PINS_RESET, PINS_RESET};
    hps_pins_s [1:0] slot_pins;
    hps_state_s [1:0] st;
    logic [1:0] main_power_on, aux_slot_output, fault_oe_n, good_oe_n;
    logic [1:0] fault_n, good_n;
    logic [1:0] main_ok, aux_ok, all_low;
    logic [3:0] common_status;
    int errors = 0;
    int num_checks = 0;
    initial
    begin
        forever #10 clock = ~clock;
    end
    hps_slot_ctl #(.DEBOUNCE_TICKS(4)) dut (
        .clock(clock), .rst(rst), .slot_pins(slot_pins),
        .thermal_shutdown(thermal_shutdown),
        .override_inhibit(override_inhibit),
        .fault_timer_cap(fault_timer_cap), .main_power_on(main_power_on),
        .aux_slot_output(aux_slot_output), .slot_fault_n(fault_n),
        .slot_fault_n_oe_n(fault_oe_n), .slot_power_good_n(good_n),
        .slot_power_good_n_oe_n(good_oe_n), .slot_state_reg(st),
        .common_status(common_status));
    hps_power_model rails (
        .clock(clock), .main_power_on(main_power_on),
        .aux_slot_output(aux_slot_output), .main_ok(main_ok),
        .aux_ok(aux_ok), .all_low(all_low));
    always_comb
    begin
        slot_pins = drv;
        for (int s = 0; s < 2; s++)
        begin
            slot_pins[s].main_in_range = main_ok[s];
            slot_pins[s].aux_in_range = aux_ok[s];
            slot_pins[s].all_below_low = all_low[s];
        end
    end
    task automatic check1(input logic got, input logic exp);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("Error at %0t: got %b expected %b", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic wait_fault(input int s, input bit aux, output int n);
        for (n = 0; n < 400; n++)
        begin
            @(negedge clock);
            if ((aux ? st[s].aux_fault : st[s].main_fault) === 1'b1)
                break;
        end
    endtask
    task automatic tally_and_finish;
        $display("Checks %0d, errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic t_main_fault;
        int n;
        @(posedge clock);
        drv[0].main_power_enable <= 1'b1;
        drv[0].aux_power_enable <= 1'b1;
        drv[0].sense_low_12v_trip <= 1'b1;
        cyc(20);
        drv[0].sense_low_12v_trip <= 1'b0;
        @(negedge clock);
        check1(main_power_on[0], 1'b1);
        check1(aux_slot_output[0], 1'b1);
        check1(good_oe_n[0], 1'b0);
        check1(good_n[0], 1'b0);
        check1(fault_n[0], 1'b0);
        check1(st[0].power_good, 1'b1);
        check1(st[0].aux_on, 1'b1);
        check1(st[0].main_on, 1'b1);
        check1(main_power_on[1], 1'b0);
        cyc(300);
        drv[0].sense_low_3v3_trip <= 1'b1;
        @(negedge clock);
        check1(fault_oe_n[0], 1'b1);
        wait_fault(0, 1'b0, n);
        check1(n >= 95 && n <= 200, 1'b1);
        cyc(3);
        drv[0].sense_low_3v3_trip <= 1'b0;
        @(negedge clock);
        check1(main_power_on[0], 1'b0);
        check1(fault_oe_n[0], 1'b0);
        check1(st[1].main_fault, 1'b0);
        cyc(10);
        drv[0].main_power_enable <= 1'b0;
        drv[0].aux_power_enable <= 1'b0;
        @(negedge clock);
        check1(st[0].main_fault, 1'b1);
        cyc(20);
        @(negedge clock);
        check1(st[0].main_fault, 1'b0);
        check1(st[0].power_off, 1'b1);
    endtask
    task automatic t_override;
        int n;
        @(posedge clock);
        drv[0].main_power_enable <= 1'b1;
        drv[0].aux_power_enable <= 1'b1;
        drv[0].slot_override_on_n <= 1'b0;
        drv[0].sense_low_3v3_trip <= 1'b1;
        wait_fault(0, 1'b0, n);
        check1(st[0].override_active, 1'b1);
        cyc(3);
        override_inhibit <= 2'h1;
        @(negedge clock);
        check1(main_power_on[0], 1'b1);
        check1(st[0].override_active, 1'b0);
        cyc(4);
        thermal_shutdown <= 1'b1;
        override_inhibit <= 2'h0;
        @(negedge clock);
        check1(main_power_on[0], 1'b0);
        cyc(6);
        @(negedge clock);
        check1(main_power_on[0], 1'b0);
        check1(st[0].thermal_off, 1'b1);
        cyc(1);
        rst <= 1'b1;
        thermal_shutdown <= 1'b0;
        drv <= {PINS_RESET, PINS_RESET};
        cyc(8);
        rst <= 1'b0;
        cyc(4);
        @(negedge clock);
        check1(fault_oe_n[0], 1'b1);
        check1(main_power_on[0], 1'b0);
    endtask
    task automatic t_aux_fault;
        int n;
        @(posedge clock);
        drv[1].aux_power_enable <= 1'b1;
        drv[1].main_power_enable <= 1'b1;
        drv[1].aux_under_voltage <= 1'b1;
        wait_fault(1, 1'b1, n);
        cyc(3);
        drv[1].aux_under_voltage <= 1'b0;
        @(negedge clock);
        check1(aux_slot_output[1], 1'b0);
        check1(main_power_on[1], 1'b0);
        check1(fault_oe_n[1], 1'b0);
        check1(fault_oe_n[0], 1'b1);
        cyc(10);
        drv[1].aux_power_enable <= 1'b0;
        @(negedge clock);
        check1(st[1].aux_fault, 1'b1);
        cyc(10);
        @(negedge clock);
        check1(st[1].aux_fault, 1'b0);
        check1(main_power_on[1], 1'b1);
    endtask
    task automatic t_debounce;
        int n;
        // A 60-cycle bounce spans two ticks at most, short of the window.
        @(posedge clock);
        drv[0].slot_general_input_1 <= 1'b1;
        cyc(60);
        drv[0].slot_general_input_1 <= 1'b0;
        cyc(300);
        drv[0].slot_general_input_1 <= 1'b1;
        drv[1].slot_general_input_2 <= 1'b1;
        @(negedge clock);
        check1(common_status[0], 1'b0);
        for (n = 0; n < 600 && common_status[0] !== 1'b1; n++)
            @(negedge clock);
        check1(n >= 140, 1'b1);
        check1(common_status === 4'h9, 1'b1);
    endtask
    initial
    begin
        cyc(8);
        rst <= 1'b0;
        t_main_fault;
        t_override;
        t_aux_fault;
        t_debounce;
        tally_and_finish;
    end
    initial
    begin
        cyc(10000);
        errors++;
        tally_and_finish;
    end
endmodule
`default_nettype wire

// ---- sim/hps_power_model.sv ----
// Rail model for the switches and monitors of both slots.
// Assumes the enables come straight from the block's switch outputs.
`timescale 1ns/1ns
`default_nettype none
module hps_power_model #(
    parameter int RAMP = 8
) (
    // Clock
    input wire logic clock,
    // Switch enables
    input wire logic [1:0] main_power_on,
    input wire logic [1:0] aux_slot_output,
    // Monitor levels
    output logic [1:0] main_ok,
    output logic [1:0] aux_ok,
    output logic [1:0] all_low
);
    // Rails ramp one step a cycle, so good and low lag the switch.
    int main_lvl_q [2];
    int aux_lvl_q [2];
    function automatic int step(input int lvl, input logic on);
        if (on)
            return (lvl < RAMP) ? lvl + 1 : RAMP;
        return (lvl > 0) ? lvl - 1 : 0;
    endfunction
    always_ff @(posedge clock)
    begin
        for (int s = 0; s < 2; s++)
        begin
            main_lvl_q[s] <= step(main_lvl_q[s], main_power_on[s]);
            aux_lvl_q[s] <= step(aux_lvl_q[s], aux_slot_output[s]);
        end
    end
    assign main_ok = {main_lvl_q[1] == RAMP, main_lvl_q[0] == RAMP};
    assign aux_ok = {aux_lvl_q[1] == RAMP, aux_lvl_q[0] == RAMP};
    assign all_low = {main_lvl_q[1] + aux_lvl_q[1] == 0,
        main_lvl_q[0] + aux_lvl_q[0] == 0};
endmodule
`default_nettype wire

// ---- sim/hps_slot_ctl_chk.sv ----
// Port assertions for the dual-slot hot plug block.
// Assumes a bind onto hps_slot_ctl; slot 0 stands for both copies.
`timescale 1ns/1ns
`default_nettype none
module hps_slot_ctl_chk #(
    parameter int unsigned DEBOUNCE_TICKS = 4
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Block ports
    input wire hps_pkg::hps_pins_s [1:0] slot_pins,
    input wire logic thermal_shutdown,
    input wire logic [1:0] override_inhibit,
    input wire logic [1:0] main_power_on,
    input wire logic [1:0] aux_slot_output,
    input wire logic [1:0] slot_fault_n_oe_n,
    input wire logic [1:0] slot_power_good_n_oe_n,
    input wire hps_pkg::hps_state_s [1:0] slot_state_reg
);
    import hps_pkg::*;
    hps_pins_s p0;
    hps_state_s s0;
    assign p0 = slot_pins[0];
    assign s0 = slot_state_reg[0];
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    chk_fault_pin_low: assert property (
        slot_fault_n_oe_n[0] == !$past(s0.main_fault || s0.aux_fault))
        else $error("fault pin mismatch");
    chk_aux_fault_hold: assert property (
        $fell(s0.aux_fault) |-> !($past(p0.aux_power_enable, 2) &&
        $past(p0.aux_power_enable, 3) && $past(p0.aux_power_enable, 4)))
        else $error("aux fault cleared with enable high");
    chk_main_fault_hold: assert property (
        $fell(s0.main_fault) |-> !($past(p0.main_power_enable, 2) &&
        $past(p0.main_power_enable, 3) && $past(p0.main_power_enable, 4)))
        else $error("main fault cleared with enable high");
    chk_fault_cuts_main: assert property (
        (s0.main_fault && !s0.override_active) [*3] |-> !main_power_on[0])
        else $error("main on during fault");
    chk_override_gate: assert property (
        (override_inhibit[0] && s0.main_fault) [*3] |-> !main_power_on[0])
        else $error("override honoured while inhibited");
    chk_thermal_cut: assert property (
        thermal_shutdown [*4] |-> main_power_on == 2'h0
        && aux_slot_output == 2'h0) else $error("on during thermal");
    chk_good_needs_range: assert property (
        (!p0.main_in_range) [*4] |-> slot_power_good_n_oe_n[0])
        else $error("power good with rail out of range");
    chk_off_needs_low: assert property (
        (!p0.all_below_low) [*4] |-> !s0.power_off)
        else $error("power off with rails up");
    chk_main_needs_en: assert property (
        (!p0.main_power_enable) [*4] |-> !main_power_on[0])
        else $error("main on without enable");
endmodule
bind hps_slot_ctl hps_slot_ctl_chk #(.DEBOUNCE_TICKS(DEBOUNCE_TICKS)) u_chk (
    .clock(clock), .rst(rst), .slot_pins(slot_pins),
    .thermal_shutdown(thermal_shutdown),
    .override_inhibit(override_inhibit),
    .main_power_on(main_power_on), .aux_slot_output(aux_slot_output),
    .slot_fault_n_oe_n(slot_fault_n_oe_n),
    .slot_power_good_n_oe_n(slot_power_good_n_oe_n),
    .slot_state_reg(slot_state_reg)
);
`default_nettype wire
